// ---- design/ssc_consts.vh ----
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// register byte offsets
`define SSC_REG_CTRL     8'h00
`define SSC_REG_CMD      8'h04
`define SSC_REG_TRIGPOL  8'h08
`define SSC_REG_SEQLEN   8'h0C
`define SSC_REG_SETSEL   8'h10
`define SSC_REG_STEPIDX  8'h14
`define SSC_REG_STEPW0   8'h18
`define SSC_REG_STEPW1   8'h1C
`define SSC_REG_STEPW2   8'h20
`define SSC_REG_STEPW3   8'h24
`define SSC_REG_STATUS   8'h28
`define SSC_REG_ELAPSED  8'h2C
// command bits
`define SSC_CMD_START    0
`define SSC_CMD_STOP     1
`define SSC_CMD_STOPEND  2
`define SSC_CMD_HOLD     3
`define SSC_CMD_RESUME   4
`define SSC_CMD_EVENT    5
// control port input bits
`define SSC_CTL_START    0
`define SSC_CTL_STOP     1
`define SSC_CTL_HOLD     2
`define SSC_CTL_EVENT    3
// trigger polarity codes and users
`define SSC_POL_OFF      2'h0
`define SSC_POL_RISE     2'h1
`define SSC_POL_FALL     2'h2
`define SSC_TU_KEYING    0
`define SSC_TU_SWEEP     1
`define SSC_TU_SEQ       2
`define SSC_TU_LOCK      3
`define SSC_TRIGPOL_RST  8'h55
// waveform codes
`define SSC_WV_SINE      3'h0
`define SSC_WV_SQUARE    3'h1
`define SSC_WV_TRI50     3'h2
`define SSC_WV_ARB       3'h3
`define SSC_WV_NOISE     3'h4
`define SSC_WV_DC        3'h5
// intra-step modes
`define SSC_MD_CONST     2'h0
`define SSC_MD_KEEP      2'h1
`define SSC_MD_INTERP    2'h2
// limits and reset values
`define SSC_MAX_STEPS    10'h3FF
`define SSC_MAX_SETS     7'h63
`define SSC_SEQLEN_RST   10'h001
`define SSC_SETSEL_RST   7'h01
`define SSC_DUR_MIN      27'h000000A
`define SSC_DUR_MAX      27'h5F5E100
`define SSC_JCNT_MAX     14'h270F
`define SSC_PHASE_MAX    19'h57E40
`define SSC_ARB_END_PH   19'h00000
// timing: one duration unit is 0.01 ms
`define SSC_CLK_PS       10000
`define SSC_UNIT_PS      10000000
`define SSC_UNIT_CYC     ((`SSC_UNIT_PS + `SSC_CLK_PS - 1) / `SSC_CLK_PS)
`endif

// ---- design/ssc_step_sequence_controller.v ----
`timescale 1ns/1ps
`include "ssc_consts.vh"

// What this block does
// RQ1 - trigger polarity rising, falling or off; off refused for frequency lock
// RQ2 - separate polarity per trigger user: keying, sweep, sequence, frequency lock
// RQ3 - sequence set number selectable from 1 to 99
// RQ4 - sequence length limited to 1023 steps
// RQ5 - both channels run under one shared step controller
// RQ6 - step duration 0.1 ms to 1000 s in 0.01 ms units
// RQ7 - per-step jump count 1 to 9999 or unlimited
// RQ8 - per-step end phase 0 to 360 degrees in millidegrees, or disabled
// RQ9 - end phase only for sine or triangle; arbitrary uses fixed phase
// RQ10 - per-channel constant, keep or interpolate; no interpolation across waveform change
// RQ11 - state branch input sampled at step end jumps to branch target
// RQ12 - event branch moves to target step immediately
// RQ13 - step end either halts or advances per step setting
// RQ14 - step sync code driven on control port while step active
// RQ15 - sync code LSB optionally routed to sync/sub output
// RQ16 - step after DC or noise restarts channels at zero phase
// RQ17 - start, stop now, stop at step end, hold, resume, event branch
// RQ18 - outside equipment drives start, stop, hold and event control lines
// RQ19 - sequence start trigger from first channel trigger with own polarity
// RQ20 - sequencing refused while frequency lock is enabled
// RQ21 - hold freezes elapsed time and outputs; resume continues
// RQ22 - unlimited jump count always jumps, never falls through
module ssc_step_sequence_controller (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire first_channel_trig_in,
    input wire [3:0] seq_ctl_in,
    input wire ch0_phase_hit,
    output reg [3:0] seq_code_out,
    output reg sync_sub_output,
    output reg [3:0] trig_user_pulse,
    output reg [1:0] ch_seq_active,
    output reg [9:0] step_index,
    output reg step_load,
    output reg [1:0] ch_phase_reset,
    output reg [2:0] ch0_wave,
    output reg [2:0] ch1_wave,
    output reg [1:0] ch0_mode,
    output reg [1:0] ch1_mode,
    output reg [18:0] end_phase,
    output reg end_phase_en,
    output reg freq_lock_en,
    output reg [6:0] set_select
);

localparam ST_IDLE = 3'h0;
localparam ST_LOAD = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_PHASE = 3'h3;
localparam ST_HOLD = 3'h4;

// ----------------------------------------
// storage and control registers
// ----------------------------------------
reg [31:0] mem_w0 [0:1023];
reg [31:0] mem_w1 [0:1023];
reg [31:0] mem_w2 [0:1023];
reg [31:0] mem_w3 [0:1023];
reg route_sync_q;
reg [7:0] trig_pol_q;
reg [9:0] seq_len_q;
reg [9:0] step_sel_q;
reg [2:0] state_q;
reg [2:0] hold_ret_q;
reg [9:0] ptr_q;
reg [26:0] elapsed_q;
reg [15:0] tick_q;
reg stop_end_q;
reg [9:0] loop_src_q;
reg [13:0] loop_cnt_q;
reg [2:0] prev_wave0_q;
reg [2:0] prev_wave1_q;
reg [31:0] w0_q;
reg [31:0] w1_q;
reg [31:0] w2_q;
reg [31:0] w3_q;

// ----------------------------------------
// input synchronisers and edges
// ----------------------------------------
reg [2:0] trig_sr_q;
reg [3:0] ctl_s1_q;
reg [3:0] ctl_s2_q;
reg [3:0] ctl_s3_q;
wire trig_rise = trig_sr_q[1] & ~trig_sr_q[2];
wire trig_fall = ~trig_sr_q[1] & trig_sr_q[2];
wire [3:0] ctl_rise = ctl_s2_q & ~ctl_s3_q;
wire [3:0] ctl_fall = ~ctl_s2_q & ctl_s3_q;
reg [3:0] user_trig;
integer u;

always @(posedge aclk) begin
    if (!aresetn) begin
        trig_sr_q <= 3'h0;
        ctl_s1_q <= 4'h0;
        ctl_s2_q <= 4'h0;
        ctl_s3_q <= 4'h0;
    end else begin
        trig_sr_q <= {trig_sr_q[1:0], first_channel_trig_in};
        ctl_s1_q <= seq_ctl_in;
        ctl_s2_q <= ctl_s1_q;
        ctl_s3_q <= ctl_s2_q;
    end
end

// RQ2 polarity per user
always @* begin
    user_trig = 4'h0;
    for (u = 0; u < 4; u = u + 1) begin
        case (trig_pol_q[2*u +: 2])
            `SSC_POL_RISE: user_trig[u] = trig_rise;
            `SSC_POL_FALL: user_trig[u] = trig_fall;
            default: user_trig[u] = 1'b0;
        endcase
    end
end

// ----------------------------------------
// register bus
// ----------------------------------------
reg aw_have_q;
reg w_have_q;
reg [7:0] aw_addr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
wire wr_go = aw_have_q & w_have_q;
wire full_word = (wstrb_q == 4'hF);
wire cmd_wr = wr_go & (aw_addr_q == `SSC_REG_CMD);
wire [5:0] cmd = cmd_wr ? wdata_q[5:0] : 6'h0;
wire busy = (state_q != ST_IDLE);
reg wr_ok;

always @* begin
    case (aw_addr_q)
        `SSC_REG_CTRL, `SSC_REG_CMD, `SSC_REG_TRIGPOL, `SSC_REG_SEQLEN, `SSC_REG_SETSEL,
        `SSC_REG_STEPIDX, `SSC_REG_STEPW0, `SSC_REG_STEPW1, `SSC_REG_STEPW2, `SSC_REG_STEPW3,
        `SSC_REG_STATUS, `SSC_REG_ELAPSED: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        aw_addr_q <= 8'h00;
        wdata_q <= 32'h0;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        route_sync_q <= 1'b0;
        freq_lock_en <= 1'b0;
        trig_pol_q <= `SSC_TRIGPOL_RST;
        seq_len_q <= `SSC_SEQLEN_RST;
        set_select <= `SSC_SETSEL_RST;
        step_sel_q <= 10'h0;
    end else begin
        if (s_axi_awvalid & s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            if (full_word) begin
                case (aw_addr_q)
                    `SSC_REG_CTRL: begin
                        route_sync_q <= wdata_q[0];
                        // RQ20 no lock while running
                        if (!busy) begin
                            freq_lock_en <= wdata_q[1];
                        end
                    end
                    `SSC_REG_TRIGPOL: begin
                        trig_pol_q[5:0] <= wdata_q[5:0];
                        // RQ1 off refused for lock
                        if (wdata_q[7:6] == `SSC_POL_RISE || wdata_q[7:6] == `SSC_POL_FALL) begin
                            trig_pol_q[7:6] <= wdata_q[7:6];
                        end
                    end
                    `SSC_REG_SEQLEN: begin
                        // RQ4 length bound
                        if (wdata_q[9:0] != 10'h0 && !busy) begin
                            seq_len_q <= wdata_q[9:0];
                        end
                    end
                    `SSC_REG_SETSEL: begin
                        // RQ3 set number bound
                        if (wdata_q[6:0] != 7'h0 && wdata_q[6:0] <= `SSC_MAX_SETS && wdata_q[31:7] == 25'h0) begin
                            set_select <= wdata_q[6:0];
                        end
                    end
                    `SSC_REG_STEPIDX: step_sel_q <= wdata_q[9:0];
                    default: begin
                    end
                endcase
            end
        end
    end
end

always @(posedge aclk) begin
    if (wr_go & full_word) begin
        case (aw_addr_q)
            `SSC_REG_STEPW0: mem_w0[step_sel_q] <= wdata_q;
            `SSC_REG_STEPW1: mem_w1[step_sel_q] <= wdata_q;
            `SSC_REG_STEPW2: mem_w2[step_sel_q] <= wdata_q;
            `SSC_REG_STEPW3: mem_w3[step_sel_q] <= wdata_q;
            default: begin
            end
        endcase
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end else if (s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[7:2], 2'b00})
            `SSC_REG_CTRL: s_axi_rdata <= {30'h0, freq_lock_en, route_sync_q};
            `SSC_REG_CMD: s_axi_rdata <= 32'h0;
            `SSC_REG_TRIGPOL: s_axi_rdata <= {24'h0, trig_pol_q};
            `SSC_REG_SEQLEN: s_axi_rdata <= {22'h0, seq_len_q};
            `SSC_REG_SETSEL: s_axi_rdata <= {25'h0, set_select};
            `SSC_REG_STEPIDX: s_axi_rdata <= {22'h0, step_sel_q};
            `SSC_REG_STEPW0: s_axi_rdata <= mem_w0[step_sel_q];
            `SSC_REG_STEPW1: s_axi_rdata <= mem_w1[step_sel_q];
            `SSC_REG_STEPW2: s_axi_rdata <= mem_w2[step_sel_q];
            `SSC_REG_STEPW3: s_axi_rdata <= mem_w3[step_sel_q];
            `SSC_REG_STATUS: s_axi_rdata <= {14'h0, seq_code_out, ptr_q, stop_end_q, state_q};
            `SSC_REG_ELAPSED: s_axi_rdata <= {5'h0, elapsed_q};
            default: begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'h2;
            end
        endcase
    end
end

// ----------------------------------------
// step field decode
// ----------------------------------------
wire [26:0] dur_raw = w0_q[26:0];
// RQ6 duration clamp
wire [26:0] dur = (dur_raw < `SSC_DUR_MIN) ? `SSC_DUR_MIN : (dur_raw > `SSC_DUR_MAX) ? `SSC_DUR_MAX : dur_raw;
wire [9:0] jmp_tgt = w1_q[9:0];
wire [13:0] jmp_cnt = (w1_q[23:10] > `SSC_JCNT_MAX) ? `SSC_JCNT_MAX : w1_q[23:10];
wire jmp_en = w1_q[24];
wire term_stop = w1_q[25];
wire [18:0] ph_raw = (w2_q[18:0] > `SSC_PHASE_MAX) ? `SSC_PHASE_MAX : w2_q[18:0];
wire [9:0] br_tgt = w2_q[29:20];
wire [2:0] nw0 = mem_w3[ptr_q][2:0];
wire [2:0] nw1 = mem_w3[ptr_q][5:3];
// RQ9 phase allowed per waveform
wire ph_ok = w2_q[19] & (w3_q[2:0] == `SSC_WV_SINE || w3_q[2:0] == `SSC_WV_TRI50 || w3_q[2:0] == `SSC_WV_ARB);
wire time_done = (elapsed_q >= dur);
// RQ22 unlimited always jumps
wire jump_take = jmp_en & ((jmp_cnt == 14'h0) | (loop_src_q != ptr_q) | (loop_cnt_q < jmp_cnt));
wire [9:0] ptr_inc = ptr_q + 10'h1;

function is_flat;
    input [2:0] w;
    begin
        is_flat = (w == `SSC_WV_NOISE) || (w == `SSC_WV_DC);
    end
endfunction

function [1:0] eff_mode;
    input [1:0] m;
    input [2:0] wn;
    input [2:0] wp;
    begin
        eff_mode = (m == `SSC_MD_INTERP && wn != wp) ? `SSC_MD_CONST : m;
    end
endfunction

// ----------------------------------------
// sequencer
// ----------------------------------------
wire go_start = (cmd[`SSC_CMD_START] | ctl_rise[`SSC_CTL_START] | user_trig[`SSC_TU_SEQ]) & ~freq_lock_en;
// RQ17 sequence operation commands
wire go_stop = cmd[`SSC_CMD_STOP] | ctl_rise[`SSC_CTL_STOP];
wire go_hold = cmd[`SSC_CMD_HOLD] | ctl_rise[`SSC_CTL_HOLD];
wire go_resume = cmd[`SSC_CMD_RESUME] | ctl_fall[`SSC_CTL_HOLD];
wire go_event = cmd[`SSC_CMD_EVENT] | ctl_rise[`SSC_CTL_EVENT];
wire step_end = (state_q == ST_RUN & time_done & ~ph_ok) | (state_q == ST_PHASE & ch0_phase_hit);

always @(posedge aclk) begin
    if (!aresetn) begin
        state_q <= ST_IDLE;
        hold_ret_q <= ST_RUN;
        ptr_q <= 10'h0;
        elapsed_q <= 27'h0;
        tick_q <= 16'h0;
        stop_end_q <= 1'b0;
        loop_src_q <= 10'h0;
        loop_cnt_q <= 14'h0;
        prev_wave0_q <= `SSC_WV_SINE;
        prev_wave1_q <= `SSC_WV_SINE;
        w0_q <= 32'h0;
        w1_q <= 32'h0;
        w2_q <= 32'h0;
        w3_q <= 32'h0;
        step_load <= 1'b0;
        ch_phase_reset <= 2'h0;
        trig_user_pulse <= 4'h0;
    end else begin
        step_load <= 1'b0;
        ch_phase_reset <= 2'h0;
        trig_user_pulse <= user_trig;
        if (cmd[`SSC_CMD_STOPEND] & busy) begin
            stop_end_q <= 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                // RQ19 RQ20 guarded start
                if (go_start) begin
                    ptr_q <= 10'h0;
                    stop_end_q <= 1'b0;
                    loop_cnt_q <= 14'h0;
                    loop_src_q <= `SSC_MAX_STEPS;
                    prev_wave0_q <= `SSC_WV_SINE;
                    prev_wave1_q <= `SSC_WV_SINE;
                    state_q <= ST_LOAD;
                end
            end
            ST_LOAD: begin
                w0_q <= mem_w0[ptr_q];
                w1_q <= mem_w1[ptr_q];
                w2_q <= mem_w2[ptr_q];
                w3_q <= mem_w3[ptr_q];
                prev_wave0_q <= w3_q[2:0];
                prev_wave1_q <= w3_q[5:3];
                elapsed_q <= 27'h0;
                tick_q <= 16'h0;
                step_load <= 1'b1;
                // RQ16 restart phase after flat step
                ch_phase_reset <= {is_flat(w3_q[5:3]) & ~is_flat(nw1), is_flat(w3_q[2:0]) & ~is_flat(nw0)};
                state_q <= ST_RUN;
            end
            ST_RUN, ST_PHASE: begin
                if (state_q == ST_RUN && !time_done) begin
                    if (tick_q == `SSC_UNIT_CYC - 1) begin
                        tick_q <= 16'h0;
                        elapsed_q <= elapsed_q + 27'h1;
                    end else begin
                        tick_q <= tick_q + 16'h1;
                    end
                end
                if (go_stop) begin
                    state_q <= ST_IDLE;
                end else if (go_event) begin
                    // RQ12 immediate branch
                    ptr_q <= br_tgt;
                    state_q <= ST_LOAD;
                end else if (go_hold) begin
                    hold_ret_q <= state_q;
                    state_q <= ST_HOLD;
                end else if (state_q == ST_RUN && time_done && ph_ok) begin
                    // RQ8 wait for end phase
                    state_q <= ST_PHASE;
                end else if (step_end) begin
                    // RQ13 RQ11 RQ7 step end decision
                    if (stop_end_q | cmd[`SSC_CMD_STOPEND]) begin
                        state_q <= ST_IDLE;
                    end else if (ctl_s2_q[`SSC_CTL_START]) begin
                        ptr_q <= br_tgt;
                        state_q <= ST_LOAD;
                    end else if (jump_take) begin
                        loop_src_q <= ptr_q;
                        loop_cnt_q <= (loop_src_q == ptr_q) ? loop_cnt_q + 14'h1 : 14'h1;
                        ptr_q <= jmp_tgt;
                        state_q <= ST_LOAD;
                    end else if (term_stop || ptr_inc >= seq_len_q) begin
                        state_q <= ST_IDLE;
                    end else begin
                        if (loop_src_q == ptr_q) begin
                            loop_src_q <= `SSC_MAX_STEPS;
                        end
                        ptr_q <= ptr_inc;
                        state_q <= ST_LOAD;
                    end
                end
            end
            ST_HOLD: begin
                // RQ21 frozen until resume
                if (go_stop) begin
                    state_q <= ST_IDLE;
                end else if (go_resume) begin
                    state_q <= hold_ret_q;
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------
// step outputs
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        seq_code_out <= 4'h0;
        sync_sub_output <= 1'b0;
        ch_seq_active <= 2'h0;
        step_index <= 10'h0;
        ch0_wave <= `SSC_WV_SINE;
        ch1_wave <= `SSC_WV_SINE;
        ch0_mode <= `SSC_MD_CONST;
        ch1_mode <= `SSC_MD_CONST;
        end_phase <= 19'h0;
        end_phase_en <= 1'b0;
    end else begin
        // RQ5 both channels together
        ch_seq_active <= {2{busy}};
        if (state_q == ST_RUN || state_q == ST_PHASE || state_q == ST_HOLD) begin
            step_index <= ptr_q;
            // RQ14 step code out
            seq_code_out <= w1_q[29:26];
            // RQ15 lsb routed
            sync_sub_output <= route_sync_q & w1_q[26];
            ch0_wave <= w3_q[2:0];
            ch1_wave <= w3_q[5:3];
            // RQ10 no interpolation across waveform change
            ch0_mode <= eff_mode(w3_q[7:6], w3_q[2:0], prev_wave0_q);
            ch1_mode <= eff_mode(w3_q[9:8], w3_q[5:3], prev_wave1_q);
            // RQ9 fixed phase for arbitrary
            end_phase <= (w3_q[2:0] == `SSC_WV_ARB) ? `SSC_ARB_END_PH : ph_raw;
            end_phase_en <= ph_ok;
        end else if (state_q == ST_IDLE) begin
            seq_code_out <= 4'h0;
            sync_sub_output <= 1'b0;
            end_phase_en <= 1'b0;
        end
    end
end

endmodule // ssc_step_sequence_controller

// ---- bench/ssc_step_sequence_controller_assertions.sv ----
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_seq_chk (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] seq_ctl_in,
    input wire [3:0] seq_code_out,
    input wire sync_sub_output,
    input wire [3:0] trig_user_pulse,
    input wire [1:0] ch_seq_active,
    input wire [9:0] step_index,
    input wire step_load,
    input wire [1:0] ch_phase_reset,
    input wire [2:0] ch0_wave,
    input wire [18:0] end_phase,
    input wire end_phase_en,
    input wire freq_lock_en,
    input wire [6:0] set_select
);
    // ----------
    // checks
    // ----------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_stop;
        $rose(seq_ctl_in[1]) && ch_seq_active[0] && !seq_ctl_in[2];
    endsequence
    sequence s_idle;
        ##[1:8] !ch_seq_active[0];
    endsequence
    sequence s_event;
        $rose(seq_ctl_in[3]) && ch_seq_active[0] && !seq_ctl_in[2];
    endsequence
    AST_STOP_NOW: assert property (s_stop |-> s_idle)
        else $error("stop line left sequencer running");
    AST_EVENT_NOW: assert property (s_event |-> ##[1:8] step_load)
        else $error("event branch did not load a step");
    AST_SHARED: assert property (ch_seq_active[0] == ch_seq_active[1])
        else $error("channels not under one step control");
    AST_PHASE_RST: assert property (|ch_phase_reset |-> step_load)
        else $error("phase reset outside step load");
    AST_SYNC_LSB: assert property (sync_sub_output |-> seq_code_out[0])
        else $error("sync output not code lsb");
    AST_TRIG_PULSE: assert property (trig_user_pulse[2] |=> !trig_user_pulse[2])
        else $error("sequence trigger pulse too long");
    AST_LOCK: assert property (freq_lock_en && !ch_seq_active[0] |=> !ch_seq_active[0])
        else $error("sequence started under frequency lock");
    AST_ARB_PHASE: assert property (end_phase_en && ch0_wave == `SSC_WV_ARB |-> end_phase == `SSC_ARB_END_PH)
        else $error("arbitrary wave end phase not fixed");
    AST_STEP_MAX: assert property (step_index < `SSC_MAX_STEPS)
        else $error("step index beyond limit");
    AST_SET_RANGE: assert property (set_select >= 7'h01 && set_select <= `SSC_MAX_SETS)
        else $error("set number out of range");
    AST_HOLD: assert property (seq_ctl_in[2] [*6] |-> $stable(step_index) && !step_load)
        else $error("step moved during hold");
endmodule // ssc_seq_chk
bind ssc_step_sequence_controller ssc_seq_chk ssc_seq_chk_i (.aclk(aclk), .aresetn(aresetn),
    .seq_ctl_in(seq_ctl_in), .seq_code_out(seq_code_out), .sync_sub_output(sync_sub_output),
    .trig_user_pulse(trig_user_pulse), .ch_seq_active(ch_seq_active), .step_index(step_index),
    .step_load(step_load), .ch_phase_reset(ch_phase_reset), .ch0_wave(ch0_wave), .end_phase(end_phase),
    .end_phase_en(end_phase_en), .freq_lock_en(freq_lock_en), .set_select(set_select));

// ---- bench/ssc_ext_ctl_model.sv ----
`timescale 1ns/1ps
module ssc_ext_ctl_model #(parameter int DLY = 3) (
    input wire aclk,
    input wire trig_lvl,
    input wire [3:0] ctl_lvl,
    output wire first_channel_trig_in,
    output wire [3:0] seq_ctl_in
);
    // ----------
    // delayed line drive
    // ----------
    logic [39:0] sh = 40'h0;
    always @(posedge aclk) begin
        sh <= {sh[34:0], trig_lvl, ctl_lvl};
    end
    assign {first_channel_trig_in, seq_ctl_in} = sh[5*DLY-5 +: 5];
endmodule // ssc_ext_ctl_model

// ---- bench/tb_step_sequence_controller.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t mismatch", $time); end end
module tb_step_sequence_controller;
    logic aclk = 0, aresetn = 0, ch0_phase_hit = 0, trig_lvl = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF, ctl_lvl = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, first_channel_trig_in;
    wire step_load, sync_sub_output, end_phase_en, freq_lock_en;
    wire [1:0] s_axi_bresp, s_axi_rresp, ch_seq_active, ch_phase_reset, ch0_mode, ch1_mode;
    wire [31:0] s_axi_rdata;
    wire [3:0] seq_ctl_in, seq_code_out, trig_user_pulse;
    wire [9:0] step_index;
    wire [2:0] ch0_wave, ch1_wave;
    wire [18:0] end_phase;
    wire [6:0] set_select;
    int error_cnt = 0, tests_run = 0, cyc = 0, n;
    logic [31:0] rs = 32'h67BC;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [31:0] sw [0:7] = '{32'hA, 32'h14000000, 32'h100000, 32'h4, 32'hA, 32'h2A000000, 32'h83039, 32'h3};
    ssc_step_sequence_controller ssc_step_sequence_controller_i (.*);
    ssc_ext_ctl_model #(.DLY(3)) ssc_ext_ctl_model_i (.aclk(aclk), .trig_lvl(trig_lvl), .ctl_lvl(ctl_lvl),
        .first_channel_trig_in(first_channel_trig_in), .seq_ctl_in(seq_ctl_in));
    // ----------
    // clock, random, monitor
    // ----------
    function automatic [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        rs <= xs(rs);
        ch0_phase_hit <= rs[3];
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
        if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task report_and_stop;
        if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wt(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] e);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awprot <= rs[2:0];
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task rd(input [7:0] a, input [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arprot <= rs[2:0];
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask
    task pl(input int b);
        ctl_lvl[b] <= 1'b1;
        wt(10);
        ctl_lvl[b] <= 1'b0;
        wt(30);
    endtask
    task tp;
        trig_lvl <= 1'b1;
        wt(10);
        trig_lvl <= 1'b0;
        wt(20);
    endtask
    // ----------
    // scenarios
    // ----------
    initial begin
        wt(2);
        aresetn <= 1'b1;
        rd(8'h08, {2'h0, 32'h55});
        rd(8'h10, {2'h0, 32'h1});
        wr(8'h10, 32'h64, 2'h0);
        rd(8'h10, {2'h0, 32'h1});
        wr(8'h10, 32'h63, 2'h0);
        `CHK(set_select, 7'h63)
        wr(8'h0C, 32'h0, 2'h0);
        rd(8'h0C, {2'h0, 32'h1});
        wr(8'h0C, 32'h3, 2'h0);
        rd(8'h40, {2'h2, 32'h0});
        wr(8'h40, 32'h0, 2'h2);
        wr(8'h08, 32'h0, 2'h0);
        rd(8'h08, {2'h0, 32'h40});
        for (int i = 0; i < 8; i++) begin
            if (i % 4 == 0) wr(8'h14, i / 4, 2'h0);
            wr(8'h18 + 8'(4 * (i % 4)), sw[i], 2'h0);
        end
        rd(8'h20, {2'h0, 32'h83039});
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        wt(30);
        rd(8'h28, {2'h0, 32'h14002});
        `CHK(sync_sub_output, 1'b1)
        `CHK(ch_seq_active, 2'h3)
        for (n = 0; n < 12000 && step_index !== 10'h1; n++) @(posedge aclk);
        wt(3);
        `CHK(seq_code_out, 4'hA)
        `CHK(sync_sub_output, 1'b0)
        `CHK({ch1_mode, ch1_wave, ch0_mode, ch0_wave}, 10'h003)
        for (n = 0; n < 12000 && ch_seq_active !== 2'h0; n++) @(posedge aclk);
        `CHK(n > 9900 && n < 10100, 1'b1)
        `CHK(seq_code_out, 4'h0)
        wr(8'h00, 32'h0, 2'h0);
        pl(0);
        ctl_lvl[2] <= 1'b1;
        wt(30);
        rd(8'h28, {2'h0, 32'h14004});
        ctl_lvl[2] <= 1'b0;
        wt(30);
        pl(3);
        `CHK(step_index, 10'h1)
        pl(1);
        `CHK(ch_seq_active, 2'h0)
        wr(8'h00, 32'h2, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        wt(20);
        `CHK(ch_seq_active, 2'h0)
        wr(8'h00, 32'h0, 2'h0);
        tp();
        `CHK(ch_seq_active, 2'h0)
        wr(8'h08, 32'h60, 2'h0);
        tp();
        `CHK(ch_seq_active, 2'h3)
        wr(8'h04, 32'h2, 2'h0);
        wt(10);
        `CHK(ch_seq_active, 2'h0)
        report_and_stop();
    end
endmodule // tb_step_sequence_controller
